// *** verilog/neg_timer_map.vh ***
// Timing constants for the link speed negotiation timers.
// Assumes a 250 MHz system clock; all timers count millisecond ticks.
`ifndef NEG_TIMER_MAP_VH
`define NEG_TIMER_MAP_VH
`define CLK_FREQ_KHZ 250000
`define TICK_DIV_CYCLES (`CLK_FREQ_KHZ)
`define T_NCYCL_MS 1652
`define T_NCINIT_MS 370
`define T_FAIL_MS 1620
`define T_SLEEP_MS 5000
`define T_WAKE_MS 900
`define T_RXCYCL_MIN_MS 2
`define T_RXCYCL_MAX_MS 30
`define T_RXCYCL_MS 30
`define T_TXCYCL_MS 154
`define MS_W 13
`endif

// *** verilog/ms_tick_gen.v ***
// Millisecond tick divider.
// Assumes one free-running system clock and synchronous reset.
`timescale 1ns/1ps
module ms_tick_gen #(
	parameter DIV = 250000
) (
	// Clock and reset
	input wire sys_clk,
	input wire rst,
	// Tick
	output reg tick
);
// Count width holds the 1 ms divide at 250 MHz
localparam [31:0] LAST_FULL = DIV - 1;
localparam [17:0] LAST = LAST_FULL[17:0];
reg [17:0] cnt_reg;
always @(posedge sys_clk) begin
	if (rst) begin
		cnt_reg <= 18'h00000;
		tick <= 1'b0;
	end else if (cnt_reg == LAST) begin
		cnt_reg <= 18'h00000;
		tick <= 1'b1;
	end else begin
		cnt_reg <= cnt_reg + 18'h00001;
		tick <= 1'b0;
	end
end
endmodule

// *** verilog/link_speed_negotiation_timers.v ***
// Speed negotiation timers: speed recording, watchdog, receiver stepping and slow-wait.
// Assumes inputs synchronous to sys_clk; the negotiation sequencer drives stage and events.
//
// Summary of operation
// [R1] After the speed-recording timer expires the transmit list may shrink to detected speeds.
// [R2] The speed-recording timer expires 1652 ms after it starts counting from zero.
// [R3] Without the 370 ms preload the watchdog expires before the speed-recording timer can expire with nothing recorded.
// [R4] Entry into master negotiation by loss of signal going false starts the timer, records nothing.
// [R5] Entry by a passed sync test records the speed at which the test passed.
// [R6] On entry in state 12 or 5B the speed-recording counter is preloaded with 370 ms.
// [R7] The slow-wait sleep phase lasts at most 5000 ms, then fast searching resumes.
// [R8] Each slow-wait transmit speed lasts between the master transmit cycle and that plus one rx cycle.
// [R9] Slow-wait transmit speed changes on one elapsed-time compare made once per rx cycle.
// [R10] During slow-wait sleep the receiver steps at the slow transmit cycling rate.
// [R11] Slow-wait periodically wakes into fast receiver cycling for at least 900 ms.
// [R12] Receiver speed steps use a receiver cycle time between 2 ms and 30 ms.
// [R13] The watchdog restarts negotiation after 1620 ms without a passed sync test; the code counts it only while the speed-recording timer runs.
// [R14] All timers count a derived millisecond tick and restart with the algorithm.
`timescale 1ns/1ps
`include "neg_timer_map.vh"
module link_speed_negotiation_timers #(
	parameter SPEEDS = 4,
	parameter TICK_DIV = `TICK_DIV_CYCLES,
	parameter RXCYCL_MS = `T_RXCYCL_MS,
	parameter TXCYCL_MS = `T_TXCYCL_MS
) (
	// Clock and reset
	input wire sys_clk,
	input wire rst,
	// Algorithm control
	input wire restart,
	input wire slow_wait_active,
	input wire enter_master,
	input wire enter_by_los,
	input wire init_state_12_5b,
	input wire receive_loss_of_signal,
	input wire sync_pass,
	input wire [1:0] sync_speed,
	// Timer results
	output reg [SPEEDS-1:0] recorded_speeds,
	output reg [SPEEDS-1:0] tx_speed_list,
	output reg ncycl_expired,
	output reg watchdog_restart,
	output reg rx_step,
	output reg tx_step,
	output reg slow_wake,
	output reg [1:0] tx_speed
);

////////////////////////////////////////////////////////////////////////
localparam SW_OFF = 2'b00;
localparam SW_SLEEP = 2'b01;
localparam SW_WAKE = 2'b10;
localparam [12:0] NCYCL = `T_NCYCL_MS;
localparam [12:0] NCINIT = `T_NCINIT_MS;
localparam [12:0] FAIL = `T_FAIL_MS;
localparam [12:0] SLEEP = `T_SLEEP_MS;
localparam [12:0] WAKE = `T_WAKE_MS;
localparam [12:0] RXC = (RXCYCL_MS < `T_RXCYCL_MIN_MS) ? `T_RXCYCL_MIN_MS :
	(RXCYCL_MS > `T_RXCYCL_MAX_MS) ? `T_RXCYCL_MAX_MS : RXCYCL_MS;
localparam [12:0] TXC = TXCYCL_MS;

function [SPEEDS-1:0] onehot;
	input [1:0] sp;
	begin
		onehot = {{(SPEEDS-1){1'b0}}, 1'b1} << sp;
	end
endfunction

// Counters hold ticks already seen; the tick in hand is the next one
function reached;
	input [12:0] cnt;
	input [12:0] lim;
	begin
		reached = (cnt + 13'h0001 >= lim);
	end
endfunction

wire tick;
reg [12:0] nc_reg;
reg nc_run_reg;
reg [12:0] wd_reg;
reg [12:0] rx_reg;
reg [12:0] tx_reg;
reg [12:0] sw_reg;
reg [1:0] sw_state_reg;
wire clr = rst | restart;
wire rx_due = tick && reached(rx_reg, RXC);
// A sync pass without signal present cannot be genuine
wire sync_ok = sync_pass && !receive_loss_of_signal;
// Expiry shrinks to the record including a pass in the same cycle
wire [SPEEDS-1:0] rec_next = sync_ok ? (recorded_speeds | onehot(sync_speed)) :
	recorded_speeds;

ms_tick_gen #(.DIV(TICK_DIV)) u_tick (
	.sys_clk(sys_clk),
	.rst(rst),
	.tick(tick)
);

////////////////////////////////////////////////////////////////////////
// Speed recording
always @(posedge sys_clk) begin
	if (clr) begin
		nc_reg <= 13'h0000; // [R14]
		nc_run_reg <= 1'b0;
		recorded_speeds <= {SPEEDS{1'b0}};
		tx_speed_list <= {SPEEDS{1'b1}};
		ncycl_expired <= 1'b0;
	end else if (enter_master) begin
		nc_run_reg <= 1'b1;
		nc_reg <= init_state_12_5b ? NCINIT : 13'h0000; // [R6]
		ncycl_expired <= 1'b0;
		if (enter_by_los)
			recorded_speeds <= {SPEEDS{1'b0}}; // [R4]
		else
			recorded_speeds <= onehot(sync_speed); // [R5]
	end else begin
		recorded_speeds <= rec_next;
		if (nc_run_reg && tick) begin
			if (reached(nc_reg, NCYCL)) begin
				nc_run_reg <= 1'b0; // [R2]
				ncycl_expired <= 1'b1;
				// Empty record at expiry keeps the current transmit list
				if (rec_next != {SPEEDS{1'b0}})
					tx_speed_list <= rec_next; // [R1] [R3]
			end else begin
				nc_reg <= nc_reg + 13'h0001;
			end
		end
	end
end

////////////////////////////////////////////////////////////////////////
// Watchdog between passed sync tests
always @(posedge sys_clk) begin
	if (clr || sync_ok || !nc_run_reg) begin
		wd_reg <= 13'h0000;
		watchdog_restart <= 1'b0;
	end else if (tick) begin
		if (reached(wd_reg, FAIL)) begin
			wd_reg <= 13'h0000;
			watchdog_restart <= 1'b1; // [R13] [R3]
		end else begin
			wd_reg <= wd_reg + 13'h0001;
			watchdog_restart <= 1'b0;
		end
	end else begin
		watchdog_restart <= 1'b0;
	end
end

////////////////////////////////////////////////////////////////////////
// Receiver cycle and slow-wait transmit delay
always @(posedge sys_clk) begin
	if (clr) begin
		rx_reg <= 13'h0000;
		tx_reg <= 13'h0000;
		rx_step <= 1'b0;
		tx_step <= 1'b0;
		tx_speed <= 2'b00;
	end else begin
		rx_step <= 1'b0;
		tx_step <= 1'b0;
		if (tick)
			rx_reg <= rx_due ? 13'h0000 : rx_reg + 13'h0001; // [R12]
		// Idle outside slow-wait so the first speed there gets a full delay
		if (!slow_wait_active)
			tx_reg <= 13'h0000;
		else if (tick)
			tx_reg <= tx_reg + 13'h0001;
		if (rx_due) begin
			// One compare per rx cycle keeps delay within one rx cycle
			if (slow_wait_active && tx_reg >= TXC) begin
				tx_reg <= 13'h0000; // [R8] [R9]
				tx_step <= 1'b1;
				tx_speed <= tx_speed + 2'b01;
				if (sw_state_reg == SW_SLEEP)
					rx_step <= 1'b1; // [R10]
			end
			if (!slow_wait_active || sw_state_reg == SW_WAKE)
				rx_step <= 1'b1; // [R12] [R11]
		end
	end
end

////////////////////////////////////////////////////////////////////////
// Slow-wait sleep and wake phases
always @(posedge sys_clk) begin
	if (clr || !slow_wait_active) begin
		sw_state_reg <= SW_OFF;
		sw_reg <= 13'h0000;
		slow_wake <= 1'b0;
	end else begin
		case (sw_state_reg)
		SW_OFF: begin
			sw_state_reg <= SW_SLEEP;
			sw_reg <= 13'h0000;
		end
		SW_SLEEP: begin
			if (tick) begin
				if (reached(sw_reg, SLEEP)) begin
					sw_state_reg <= SW_WAKE; // [R7]
					sw_reg <= 13'h0000;
					slow_wake <= 1'b1;
				end else begin
					sw_reg <= sw_reg + 13'h0001;
				end
			end
		end
		SW_WAKE: begin
			if (tick) begin
				if (reached(sw_reg, WAKE)) begin
					sw_state_reg <= SW_SLEEP; // [R11]
					sw_reg <= 13'h0000;
					slow_wake <= 1'b0;
				end else begin
					sw_reg <= sw_reg + 13'h0001;
				end
			end
		end
		default: sw_state_reg <= SW_OFF;
		endcase
	end
end

endmodule

// *** sim/neg_timers_monitor.sv ***
// Timer output assertions.
// Bound to the timer top; sees its ports only.
`timescale 1ns/1ps
module neg_timers_monitor #(parameter SPEEDS = 4) (
	// Clock and reset
	input wire sys_clk,
	input wire rst,
	// Watched ports
	input wire restart,
	input wire [SPEEDS-1:0] recorded_speeds,
	input wire [SPEEDS-1:0] tx_speed_list,
	input wire ncycl_expired,
	input wire watchdog_restart,
	input wire rx_step,
	input wire tx_step,
	input wire [1:0] tx_speed
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence expiry_s;
		$rose(ncycl_expired);
	endsequence
	wd_pulse_a: assert property (watchdog_restart |=> !watchdog_restart)
		else $error("long wd pulse");
	rx_pulse_a: assert property (rx_step |=> !rx_step)
		else $error("long rx step");
	tx_with_rx_a: assert property (tx_step |-> rx_step)
		else $error("lone tx step");
	tx_advance_a: assert property (tx_step |-> tx_speed == $past(tx_speed) + 2'h1)
		else $error("tx speed stuck");
	list_shrink_a: assert property (expiry_s |->
		tx_speed_list == (|recorded_speeds ? recorded_speeds : $past(tx_speed_list)))
		else $error("list not shrunk");
	wd_first_a: assert property (watchdog_restart |-> !$past(ncycl_expired))
		else $error("wd after expiry");
	restart_clear_a: assert property (restart |=> !ncycl_expired && !watchdog_restart)
		else $error("restart kept state");
	reset_value_a: assert property (disable iff (1'b0) rst |=> &tx_speed_list)
		else $error("bad reset list");
endmodule
////////////////////////////////
bind link_speed_negotiation_timers neg_timers_monitor #(.SPEEDS(SPEEDS)) mon (
	.sys_clk(sys_clk), .rst(rst), .restart(restart), .recorded_speeds(recorded_speeds),
	.tx_speed_list(tx_speed_list), .ncycl_expired(ncycl_expired), .tx_speed(tx_speed),
	.watchdog_restart(watchdog_restart), .rx_step(rx_step), .tx_step(tx_step));

// *** sim/peer_port_model.sv ***
// Remote port: passes a sync test once per rx cycle.
// Rx cycle is 60 clocks, 30 ms at the bench tick.
`timescale 1ns/1ps
module peer_port_model (
	// Clock and reset
	input wire sys_clk,
	input wire rst,
	// Control
	input wire run,
	input wire [1:0] speed,
	// Sync result
	output reg sync_pass,
	output reg [1:0] sync_speed
);
	reg [5:0] cnt_reg;
	always @(posedge sys_clk) begin
		cnt_reg <= (rst || !run || cnt_reg == 6'h3b) ? 6'h0 : cnt_reg + 6'h1;
		sync_pass <= run && cnt_reg == 6'h3b;
		sync_speed <= speed;
	end
endmodule

// *** sim/test_link_speed_negotiation_timers.sv ***
// Bench for the negotiation timers.
// Short tick divider; spans are counted in ticks.
`timescale 1ns/1ps
module test_link_speed_negotiation_timers;
	localparam DIV = 2;
	reg sys_clk, rst = 1'b1, restart = 1'b0, slow_wait_active = 1'b0;
	reg enter_master = 1'b0, enter_by_los = 1'b0, init_state_12_5b = 1'b0;
	reg run = 1'b0;
	reg [1:0] speed = 2'h2;
	wire sync_pass, ncycl_expired, watchdog_restart, rx_step, tx_step, slow_wake;
	wire [1:0] sync_speed, tx_speed;
	wire [3:0] recorded_speeds, tx_speed_list;
	integer n_mismatch = 0, checked = 0, n, total;
	peer_port_model peer (.sys_clk(sys_clk), .rst(rst), .run(run), .speed(speed),
		.sync_pass(sync_pass), .sync_speed(sync_speed));
	link_speed_negotiation_timers #(.TICK_DIV(DIV)) DUT (.sys_clk(sys_clk), .rst(rst),
		.restart(restart), .slow_wait_active(slow_wait_active), .enter_master(enter_master),
		.enter_by_los(enter_by_los), .init_state_12_5b(init_state_12_5b),
		.receive_loss_of_signal(!run), .sync_pass(sync_pass), .sync_speed(sync_speed),
		.recorded_speeds(recorded_speeds), .tx_speed_list(tx_speed_list),
		.ncycl_expired(ncycl_expired), .watchdog_restart(watchdog_restart),
		.rx_step(rx_step), .tx_step(tx_step), .slow_wake(slow_wake), .tx_speed(tx_speed));
	////////////////////////////////
	task close_out;
		if (n_mismatch == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task check(input logic [3:0] got, input logic [3:0] want);
		checked = checked + 1;
		if (got !== want) begin
			n_mismatch = n_mismatch + 1;
			$display("BAD %0t %h %h", $time, got, want);
		end
	endtask
	// Tick phase is unknown, so spans allow slack
	task span(input integer lo, input integer hi);
		check({3'h0, n >= lo * DIV && n <= hi * DIV}, 4'h1);
	endtask
	task wait_on(input integer sel);
		n = 0;
		do begin
			@(negedge sys_clk);
			n = n + 1;
		end while ((sel == 0 ? ncycl_expired : sel == 1 ? watchdog_restart :
			sel == 2 ? tx_step : sel == 3 ? slow_wake : sel == 4 ? !slow_wake : rx_step) !== 1'b1
			&& n < 30000);
	endtask
	task enter(input logic by_los, input logic pre);
		@(posedge sys_clk);
		enter_master <= 1'b1;
		enter_by_los <= by_los;
		init_state_12_5b <= pre;
		@(posedge sys_clk);
		enter_master <= 1'b0;
		@(negedge sys_clk);
	endtask
	////////////////////////////////
	task t_record;
		@(posedge sys_clk);
		run <= 1'b1;
		enter(1'b1, 1'b0);
		check(recorded_speeds, 4'h0);
		wait_on(0);
		span(1650, 1653);
		check(tx_speed_list, 4'h4);
		speed <= 2'h1;
		@(posedge sys_clk);
		enter(1'b0, 1'b1);
		check(recorded_speeds, 4'h2);
		wait_on(0);
		span(1280, 1283);
		check(tx_speed_list, 4'h2);
	endtask
	task t_watchdog;
		@(posedge sys_clk);
		run <= 1'b0;
		enter(1'b1, 1'b0);
		wait_on(1);
		span(1618, 1621);
		check({3'h0, ncycl_expired}, 4'h0);
		wait_on(5);
		wait_on(5);
		span(30, 30);
		check(tx_speed_list, 4'h2);
	endtask
	task t_slow;
		@(posedge sys_clk);
		restart <= 1'b1;
		@(posedge sys_clk);
		restart <= 1'b0;
		slow_wait_active <= 1'b1;
		wait_on(2);
		total = n;
		wait_on(2);
		span(154, 185);
		total = total + n;
		wait_on(3);
		n = n + total;
		span(4998, 5002);
		wait_on(4);
		span(900, 902);
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	initial begin
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
		@(negedge sys_clk);
		check(tx_speed_list, 4'hf);
		t_record;
		t_watchdog;
		t_slow;
		close_out;
	end
	initial begin
		repeat (40000) @(posedge sys_clk);
		n_mismatch = n_mismatch + 1;
		close_out;
	end
endmodule
